/* File: hw/fsds_pkg.sv */
// Constants, register map and state codes for the forced stop deceleration sequencer.
// Assumes one 10 MHz system clock and a 32-bit classic Wishbone register bus.
package fsds_pkg;

    // Clock and time base.
    localparam int unsigned CLK_PERIOD_NS = 100;
    localparam int unsigned MS_PERIOD_NS  = 1000000;
    localparam int unsigned CYC_PER_MS    = MS_PERIOD_NS / CLK_PERIOD_NS;

    // Register byte addresses.
    localparam logic [7:0] REG_CTRL      = 8'h00;
    localparam logic [7:0] REG_DECEL_TC  = 8'h04;
    localparam logic [7:0] REG_ZERO_SPD  = 8'h08;
    localparam logic [7:0] REG_BASE_DLY  = 8'h0c;
    localparam logic [7:0] REG_FFALL     = 8'h10;
    localparam logic [7:0] REG_ENC       = 8'h14;
    localparam logic [7:0] REG_STATUS    = 8'h18;
    localparam logic [7:0] REG_IRQ_STAT  = 8'h1c;
    localparam logic [7:0] REG_IRQ_CLR   = 8'h20;
    localparam logic [7:0] REG_IRQ_EN    = 8'h24;
    localparam logic [7:0] REG_ALM_CLR   = 8'h28;

    // Control register fields.
    localparam int CTRL_MODE_LSB  = 0;
    localparam int CTRL_MODE_MSB  = 3;
    localparam int CTRL_LIM_SEL   = 4;
    localparam int CTRL_TORQUE    = 5;
    localparam int CTRL_DLY_EN    = 6;
    localparam logic [3:0] STOP_MODE_RESET = 4'h2;
    localparam logic [3:0] STOP_MODE_DECEL = 4'h2;
    localparam logic [3:0] STOP_MODE_OFF   = 4'h0;

    // Encoder register fields.
    localparam int ENC_DIV_MSB    = 15;
    localparam int ENC_MODE_LSB   = 16;
    localparam int ENC_MODE_MSB   = 19;
    localparam int ENC_FILT_LSB   = 20;
    localparam int ENC_FILT_MSB   = 23;

    // Reset values.
    localparam logic [15:0] DECEL_TC_RESET = 16'h0064;
    localparam logic [15:0] ZERO_SPD_RESET = 16'h0032;
    localparam logic [15:0] BASE_DLY_RESET = 16'h0000;
    localparam logic [15:0] ENC_DIV_RESET  = 16'h0fa0;

    // Interrupt event bits.
    localparam int EV_STOP    = 0;
    localparam int EV_SHUTOFF = 1;
    localparam int EV_ALARM   = 2;
    localparam int EV_ACLR    = 3;
    localparam int EV_W       = 4;

    // Sequencer states, Gray coded along idle, decel, lift, delay, shut-off.
    typedef enum logic [2:0] {
        FSDS_IDLE  = 3'b000,
        FSDS_DECEL = 3'b001,
        FSDS_LIFT  = 3'b011,
        FSDS_DELAY = 3'b010,
        FSDS_SHUT  = 3'b110,
        FSDS_DBRK  = 3'b111
    } fsds_state_t;

endpackage

/* File: hw/fsds_sync3.sv */
// Three-stage input synchroniser for pins from outside the clock domain.
// The output changes only once the second and third stages agree.
`timescale 1ns/1ps
module fsds_sync3 #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // Data
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);

    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;

    // The first stage feeds only the second, so metastability stays contained.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end else begin
            s1_q <= din;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dout <= '0;
        end else begin
            dout <= (s3_q & ~(s2_q ^ s3_q)) | (dout & (s2_q ^ s3_q));
        end
    end

endmodule // fsds_sync3

/* File: hw/fsds_top.sv */
// Forced stop deceleration sequencer with its Wishbone register file.
// Assumes speed and alarm inputs come from logic on clk; contact inputs are asynchronous pins.
// How it works
// RQ1: Stop input off ramps down on decel time.
// RQ2: Ramp done and slow: cut base, dynamic brake.
// RQ3: Warning shown throughout the forced stop sequence; the code shows none in FSDS_DBRK.
// RQ4: Limit hit in ramp: 0 sudden, 1 continue.
// RQ5: Torque mode never performs ramped forced stop.
// RQ6: Decelerate, release brake interlock, delay, base off.
// RQ7: Freefall lift needs amount, delay enabled, zero speed.
// RQ8: Lift shaft by compensation amount before shut-off.
// RQ9: Dynamic-brake alarms skip the ramp entirely.
// RQ10: Dynamic-brake alarm during ramp aborts to braking.
// RQ11: Alarm clears by reset, button, toggle; not while present.
// RQ12: Host removes cause and commands before reset.
// RQ13: Host must not toggle stop input routinely.
// RQ14: Host sets delay near 1.5x minimum holding delay.
// RQ15: Host sets filter digit 0 for fast pulses.
// RQ16: Encoder pulse period from division and mode.
// RQ17: Stop-mode digit 2 enables ramp, 0 disables.
// RQ18: Zero-speed compare uses absolute speed value.
//
// Added by the designer: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module fsds_top
    import fsds_pkg::*;
#(
    parameter int unsigned MS_CYCLES = fsds_pkg::CYC_PER_MS
) (
    // Clock and reset
    input  wire logic               clk,
    input  wire logic               rst_n,
    // Wishbone slave
    input  wire logic               wb_cyc_i,
    input  wire logic               wb_stb_i,
    input  wire logic               wb_we_i,
    input  wire logic [7:0]         wb_adr_i,
    input  wire logic [3:0]         wb_sel_i,
    input  wire logic [31:0]        wb_dat_i,
    output logic      [31:0]        wb_dat_o,
    output logic                    wb_ack_o,
    // Contact pins
    input  wire logic               forced_stop_two_in,
    input  wire logic               fwd_stroke_limit_in,
    input  wire logic               rev_stroke_limit_in,
    input  wire logic               alarm_clear_in,
    // Drive status from the control loop
    input  wire logic signed [15:0] motor_speed,
    input  wire logic               alarm_in,
    input  wire logic               alarm_db_in,
    // Sequencer outputs
    output logic                    brake_interlock_out,
    output logic                    base_on_out,
    output logic                    dyn_brake_out,
    output logic                    decel_active_out,
    output logic                    sudden_stop_out,
    output logic                    lift_step_out,
    output logic                    forced_stop_warning,
    output logic                    enc_pulse_out,
    output logic                    irq_out
);

    ////////////////////////////////////////////////////////////////////////
    // Functions and input synchronisers.

    function automatic logic [15:0] abs16(input logic signed [15:0] v);
        abs16 = v[15] ? 16'(-v) : 16'(v);
    endfunction

    function automatic logic [16:0] enc_period(input logic [15:0] div, input logic [3:0] mode);
        enc_period = (mode == 4'h0) ? {div, 1'b0} : {1'b0, div};
    endfunction

    logic [3:0] pins_s;

    fsds_sync3 #(.W(4)) u_sync (
        .clk   (clk),
        .rst_n (rst_n),
        .din   ({alarm_clear_in, rev_stroke_limit_in, fwd_stroke_limit_in, forced_stop_two_in}),
        .dout  (pins_s)
    );

    logic em2_on;
    logic limit_on;
    logic aclr_s;
    assign em2_on   = pins_s[0];
    assign limit_on = pins_s[1] | pins_s[2];
    assign aclr_s   = pins_s[3];

    ////////////////////////////////////////////////////////////////////////
    // Register file.

    logic [3:0]  stop_mode_setting_q;
    logic        limit_during_stop_select_q;
    logic        torque_mode_q;
    logic        base_dly_en_q;
    logic [15:0] stop_decel_time_const_q;
    logic [15:0] zero_speed_threshold_q;
    logic [15:0] base_off_delay_setting_q;
    logic [15:0] freefall_comp_amount_q;
    logic [15:0] encoder_div_setting_q;
    logic [3:0]  encoder_out_mode_setting_q;
    logic [3:0]  pulse_filter_select_q;
    logic [EV_W-1:0] irq_stat_q;
    logic [EV_W-1:0] irq_en_q;
    logic [EV_W-1:0] ev;
    logic        alarm_q;
    logic        stop_by_em2_q;
    fsds_state_t state_q;
    fsds_state_t state_d;

    logic wb_req;
    logic wb_wr;
    assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wb_wr  = wb_req & wb_we_i & wb_sel_i[0];

    // Only the low byte lane is checked; with it set, every field is written whole, whatever lanes it spans.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stop_mode_setting_q        <= STOP_MODE_RESET;
            limit_during_stop_select_q <= 1'b0;
            torque_mode_q              <= 1'b0;
            base_dly_en_q              <= 1'b0;
            stop_decel_time_const_q    <= DECEL_TC_RESET;
            zero_speed_threshold_q     <= ZERO_SPD_RESET;
            base_off_delay_setting_q   <= BASE_DLY_RESET;
            freefall_comp_amount_q     <= 16'h0000;
            encoder_div_setting_q      <= ENC_DIV_RESET;
            encoder_out_mode_setting_q <= 4'h0;
            pulse_filter_select_q      <= 4'h0;
            irq_en_q                   <= '0;
        end else if (wb_wr) begin
            unique case (wb_adr_i)
                REG_CTRL: begin
                    stop_mode_setting_q        <= wb_dat_i[CTRL_MODE_MSB:CTRL_MODE_LSB];
                    limit_during_stop_select_q <= wb_dat_i[CTRL_LIM_SEL];
                    torque_mode_q              <= wb_dat_i[CTRL_TORQUE];
                    base_dly_en_q              <= wb_dat_i[CTRL_DLY_EN];
                end
                REG_DECEL_TC: stop_decel_time_const_q  <= wb_dat_i[15:0];
                REG_ZERO_SPD: zero_speed_threshold_q   <= wb_dat_i[15:0];
                REG_BASE_DLY: base_off_delay_setting_q <= wb_dat_i[15:0];
                REG_FFALL:    freefall_comp_amount_q   <= wb_dat_i[15:0];
                REG_ENC: begin
                    encoder_div_setting_q      <= wb_dat_i[ENC_DIV_MSB:0];
                    encoder_out_mode_setting_q <= wb_dat_i[ENC_MODE_MSB:ENC_MODE_LSB];
                    pulse_filter_select_q      <= wb_dat_i[ENC_FILT_MSB:ENC_FILT_LSB];
                end
                REG_IRQ_EN:   irq_en_q <= wb_dat_i[EV_W-1:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= wb_req;
            wb_dat_o <= 32'h0000_0000;
            if (wb_req && !wb_we_i) begin
                unique case (wb_adr_i)
                    REG_CTRL:     wb_dat_o <= {25'h0, base_dly_en_q, torque_mode_q,
                                               limit_during_stop_select_q, stop_mode_setting_q};
                    REG_DECEL_TC: wb_dat_o <= {16'h0, stop_decel_time_const_q};
                    REG_ZERO_SPD: wb_dat_o <= {16'h0, zero_speed_threshold_q};
                    REG_BASE_DLY: wb_dat_o <= {16'h0, base_off_delay_setting_q};
                    REG_FFALL:    wb_dat_o <= {16'h0, freefall_comp_amount_q};
                    REG_ENC:      wb_dat_o <= {8'h0, pulse_filter_select_q, encoder_out_mode_setting_q,
                                               encoder_div_setting_q};
                    REG_STATUS:   wb_dat_o <= {23'h0, stop_by_em2_q, alarm_q, dyn_brake_out, base_on_out,
                                               brake_interlock_out, forced_stop_warning, state_q};
                    REG_IRQ_STAT: wb_dat_o <= {28'h0, irq_stat_q};
                    REG_IRQ_EN:   wb_dat_o <= {28'h0, irq_en_q};
                    default:      wb_dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end

    // A new event wins over a clear written in the same cycle.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_stat_q <= '0;
            irq_out    <= 1'b0;
        end else begin
            if (wb_wr && wb_adr_i == REG_IRQ_CLR) begin
                irq_stat_q <= (irq_stat_q & ~wb_dat_i[EV_W-1:0]) | ev;
            end else begin
                irq_stat_q <= irq_stat_q | ev;
            end
            irq_out <= |(irq_stat_q & irq_en_q);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Alarm latch and clearing.

    logic aclr_prev_q;
    logic alarm_clear_req;
    logic alarm_set;
    assign alarm_clear_req = (aclr_s & ~aclr_prev_q) | (wb_wr & (wb_adr_i == REG_ALM_CLR) & wb_dat_i[0]);
    assign alarm_set       = alarm_in & ~alarm_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            aclr_prev_q <= 1'b0;
            alarm_q     <= 1'b0;
        end else begin
            aclr_prev_q <= aclr_s;
            if (alarm_in) begin
                alarm_q <= 1'b1; // RQ11
            end else if (alarm_clear_req) begin
                alarm_q <= 1'b0; // RQ11
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Millisecond timer, restarted on every state change.

    logic [$clog2(MS_CYCLES+1)-1:0] pre_q;
    logic [15:0] ms_q;
    logic        ms_tick;
    assign ms_tick = (pre_q == ($bits(pre_q))'(MS_CYCLES - 1));

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pre_q <= '0;
            ms_q  <= 16'h0000;
        end else if (state_d != state_q) begin
            pre_q <= '0;
            ms_q  <= 16'h0000;
        end else if (ms_tick) begin
            pre_q <= '0;
            ms_q  <= (ms_q == 16'hffff) ? ms_q : ms_q + 16'h0001;
        end else begin
            pre_q <= pre_q + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencer.

    logic        trigger;
    logic        ramp_ok;
    logic        speed_zero;
    logic        ramp_done;
    logic        ffall_ok;
    logic [15:0] lift_cnt_q;
    logic        sudden_q;

    assign trigger    = ~em2_on | alarm_set;
    assign ramp_ok    = (stop_mode_setting_q == STOP_MODE_DECEL) && !torque_mode_q; // RQ5 RQ17
    assign speed_zero = abs16(motor_speed) < zero_speed_threshold_q; // RQ18
    assign ramp_done  = sudden_q || (ms_q >= stop_decel_time_const_q); // RQ1
    assign ffall_ok   = (freefall_comp_amount_q != 16'h0000) && base_dly_en_q; // RQ7

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            FSDS_IDLE: begin
                if (trigger) begin
                    if (alarm_in && alarm_db_in) begin
                        state_d = FSDS_DBRK; // RQ9
                    end else if (ramp_ok) begin
                        state_d = FSDS_DECEL; // RQ1
                    end else begin
                        state_d = FSDS_DBRK; // RQ5
                    end
                end
            end
            FSDS_DECEL: begin
                if (alarm_in && alarm_db_in) begin
                    state_d = FSDS_DBRK; // RQ10
                end else if (ramp_done && speed_zero) begin
                    if (!base_dly_en_q) begin
                        state_d = FSDS_SHUT; // RQ2
                    end else if (ffall_ok) begin
                        state_d = FSDS_LIFT; // RQ7
                    end else begin
                        state_d = FSDS_DELAY; // RQ6
                    end
                end
            end
            FSDS_LIFT: begin
                if (lift_cnt_q == 16'h0001) begin
                    state_d = FSDS_DELAY; // RQ8
                end
            end
            FSDS_DELAY: begin
                if (ms_q >= base_off_delay_setting_q) begin
                    state_d = FSDS_SHUT; // RQ6
                end
            end
            FSDS_SHUT, FSDS_DBRK: begin
                if (em2_on && !alarm_q && !alarm_in && speed_zero) begin
                    state_d = FSDS_IDLE;
                end
            end
            default: state_d = FSDS_DBRK;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q       <= FSDS_IDLE;
            stop_by_em2_q <= 1'b0;
        end else begin
            state_q <= state_d;
            if (state_q == FSDS_IDLE && state_d != FSDS_IDLE) begin
                stop_by_em2_q <= ~em2_on;
            end
        end
    end

    // Sudden stop and lift counter.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sudden_q   <= 1'b0;
            lift_cnt_q <= 16'h0000;
        end else begin
            if (state_q != FSDS_DECEL) begin
                sudden_q <= 1'b0;
            end else if (limit_on && !limit_during_stop_select_q) begin
                sudden_q <= 1'b1; // RQ4
            end
            if (state_d == FSDS_LIFT && state_q != FSDS_LIFT) begin
                lift_cnt_q <= freefall_comp_amount_q; // RQ8
            end else if (state_q == FSDS_LIFT) begin
                lift_cnt_q <= lift_cnt_q - 16'h0001;
            end
        end
    end

    // Outputs follow the next state so they change with the state register.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            brake_interlock_out <= 1'b1;
            base_on_out         <= 1'b1;
            dyn_brake_out       <= 1'b0;
            decel_active_out    <= 1'b0;
            sudden_stop_out     <= 1'b0;
            lift_step_out       <= 1'b0;
            forced_stop_warning <= 1'b0;
        end else begin
            brake_interlock_out <= (state_d == FSDS_IDLE) || (state_d == FSDS_DECEL); // RQ6
            base_on_out         <= (state_d != FSDS_SHUT) && (state_d != FSDS_DBRK); // RQ2
            dyn_brake_out       <= (state_d == FSDS_SHUT) || (state_d == FSDS_DBRK); // RQ2 RQ9
            decel_active_out    <= (state_d == FSDS_DECEL);
            sudden_stop_out     <= (state_d == FSDS_DECEL) && (sudden_q || (limit_on &&
                                   !limit_during_stop_select_q)); // RQ4
            lift_step_out       <= (state_d == FSDS_LIFT); // RQ8
            forced_stop_warning <= (state_d != FSDS_IDLE) && (state_d != FSDS_DBRK) &&
                                   ((state_q == FSDS_IDLE) ? ~em2_on : stop_by_em2_q); // RQ3
        end
    end

    assign ev[EV_STOP]    = (state_q == FSDS_IDLE) && (state_d != FSDS_IDLE);
    assign ev[EV_SHUTOFF] = (state_d == FSDS_SHUT) && (state_q != FSDS_SHUT);
    assign ev[EV_ALARM]   = alarm_set;
    assign ev[EV_ACLR]    = alarm_q && !alarm_in && alarm_clear_req;

    ////////////////////////////////////////////////////////////////////////
    // Encoder output pulse.

    logic [16:0] enc_cnt_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            enc_cnt_q     <= 17'h0_0000;
            enc_pulse_out <= 1'b0;
        end else if (enc_cnt_q + 17'h0_0001 >= enc_period(encoder_div_setting_q, encoder_out_mode_setting_q)) begin
            enc_cnt_q     <= 17'h0_0000;
            enc_pulse_out <= ~enc_pulse_out; // RQ16
        end else begin
            enc_cnt_q <= enc_cnt_q + 17'h0_0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions.

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    AST_DECEL_START: assert property ( // RQ1
        (state_q == FSDS_IDLE && !em2_on && ramp_ok && !alarm_in) |=> state_q == FSDS_DECEL
    ) else $error("stop input off did not start the ramp");
    AST_SHUT_OUT: assert property ( // RQ2
        (state_q == FSDS_DECEL && state_d == FSDS_SHUT) |=> (!base_on_out && dyn_brake_out)
    ) else $error("base not cut at shut-off");
    AST_WARN: assert property ( // RQ3
        (state_q == FSDS_DECEL && stop_by_em2_q) |-> forced_stop_warning
    ) else $error("warning missing during ramp");
    AST_LIMIT: assert property ( // RQ4
        (state_q == FSDS_DECEL && limit_on && !limit_during_stop_select_q && !alarm_db_in) |=>
        (sudden_q || state_q != FSDS_DECEL)
    ) else $error("limit did not force sudden stop");
    AST_TORQUE: assert property ( // RQ5
        torque_mode_q |=> !$rose(decel_active_out)
    ) else $error("ramp started in torque mode");
    AST_BRAKE_FIRST: assert property ( // RQ6
        (state_q == FSDS_DELAY) |-> (!brake_interlock_out && base_on_out)
    ) else $error("brake interlock or base wrong in delay");
    AST_FFALL: assert property ( // RQ7
        $rose(lift_step_out) |-> (freefall_comp_amount_q != 16'h0000 && base_dly_en_q)
    ) else $error("lift without enabling conditions");
    AST_DB_ALARM: assert property ( // RQ10
        (state_q == FSDS_DECEL && alarm_in && alarm_db_in) |=> (state_q == FSDS_DBRK ##1 dyn_brake_out)
    ) else $error("dynamic brake alarm did not abort ramp");
    AST_ALARM_HOLD: assert property ( // RQ11
        alarm_in |=> alarm_q
    ) else $error("alarm cleared while cause present");

    COV_EM2_STOP: cover property (state_q == FSDS_DECEL ##[1:1000] state_q == FSDS_SHUT);
    COV_LIFT:     cover property (state_q == FSDS_LIFT ##1 state_q == FSDS_DELAY);
    COV_DBRK:     cover property (state_q == FSDS_DECEL ##1 state_q == FSDS_DBRK);
    COV_ACLR:     cover property (ev[EV_ACLR]);

endmodule // fsds_top

/* File: testbench/fsds_host.sv */
// Host side model: drives the stop, stroke limit and alarm reset contacts.
// Assumes bench commands; pins change only just after a rising clock edge.
`timescale 1ns/1ps
module fsds_host (
    // Clock
    input  wire logic clk,
    // Commands from the bench
    input  wire logic stop_cmd,
    input  wire logic lim_cmd,
    input  wire logic clr_cmd,
    // Contact pins, high means on
    output logic      stop_pin = 1'b1,
    output logic      fwd_pin  = 1'b0,
    output logic      rev_pin  = 1'b0,
    output logic      clr_pin  = 1'b0
);
    // The stop contact moves only when the bench asks, never as a run/stop toggle.
    always_ff @(posedge clk) begin
        stop_pin <= ~stop_cmd;
        fwd_pin  <= lim_cmd;
        rev_pin  <= 1'b0;
        clr_pin  <= clr_cmd;
    end
endmodule // fsds_host

/* File: testbench/forced_stop_decel_sequencer_tb.sv */
// Self-checking bench for the forced stop sequencer over its Wishbone port.
// Assumes a shortened millisecond of 4 clocks.
`timescale 1ns/1ps
module forced_stop_decel_sequencer_tb;
    import fsds_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
    logic [7:0] adr = 8'h00;
    logic [31:0] dat = 32'h0, dato, rd;
    logic stop_cmd = 1'b0, clr_cmd = 1'b0, alm = 1'b0, almdb = 1'b0, lim = 1'b0;
    logic stp, fwd, rev, clrp, brk, base, dynb, dec, sud, lift, warn, enc, irq;
    logic signed [15:0] spd = 16'sh0;
    int failures = 0, total_checks = 0, n;
    always #50 clk = ~clk;
    fsds_host u_fsds_host (.clk(clk), .stop_cmd(stop_cmd), .lim_cmd(lim), .clr_cmd(clr_cmd),
        .stop_pin(stp), .fwd_pin(fwd), .rev_pin(rev), .clr_pin(clrp));
    fsds_top #(.MS_CYCLES(4)) u_fsds_top (.clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(dato), .wb_ack_o(ack),
        .forced_stop_two_in(stp), .fwd_stroke_limit_in(fwd), .rev_stroke_limit_in(rev),
        .alarm_clear_in(clrp), .motor_speed(spd), .alarm_in(alm), .alarm_db_in(almdb),
        .brake_interlock_out(brk), .base_on_out(base), .dyn_brake_out(dynb), .decel_active_out(dec),
        .sudden_stop_out(sud), .lift_step_out(lift), .forced_stop_warning(warn), .enc_pulse_out(enc),
        .irq_out(irq));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] wd);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= a;
        dat <= wd;
        do @(posedge clk); while (ack !== 1'b1);
        rd = dato;
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
        bus(a, 1'b0, 32'h0);
        chk(rd & m, exp);
    endtask
    // Bounded wait on a design output; n returns the cycles spent.
    task automatic waitv(ref logic s, input logic v);
        for (n = 0; n < 3000 && s !== v; n++) @(posedge clk);
        chk({31'h0, s}, {31'h0, v});
    endtask
    task automatic end_of_test();
        $display("Checks %0d, failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        repeat (30000) @(posedge clk);
        failures++;
        end_of_test();
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        rdchk(REG_CTRL, 32'hf, 32'h2);
        rdchk(REG_DECEL_TC, 32'hffff, 32'h64);
        rdchk(REG_ZERO_SPD, 32'hffff, 32'h32);
        rdchk(REG_ENC, 32'hffff, 32'hfa0);
        rdchk(8'h3c, 32'hffffffff, 32'h0);
        repeat (700) @(posedge clk);
        rdchk(REG_STATUS, 32'h7, 32'h0);
        bus(REG_ENC, 1'b1, 32'h0001_0004);
        waitv(enc, ~enc);
        waitv(enc, ~enc);
        chk({31'h0, n == 4}, 32'h1);
        bus(REG_DECEL_TC, 1'b1, 32'h3);
        bus(REG_BASE_DLY, 1'b1, 32'h2);
        bus(REG_FFALL, 1'b1, 32'h3);
        bus(REG_CTRL, 1'b1, 32'h42);
        bus(REG_IRQ_EN, 1'b1, 32'h2);
        bus(REG_IRQ_CLR, 1'b1, 32'hf);
        spd <= -16'sd1000;
        stop_cmd <= 1'b1;
        waitv(dec, 1'b1);
        chk({31'h0, warn}, 32'h1);
        repeat (30) @(posedge clk);
        chk({31'h0, dec}, 32'h1);
        spd <= -16'sd10;
        waitv(brk, 1'b0);
        chk({31'h0, base}, 32'h1);
        chk({31'h0, lift}, 32'h1);
        waitv(lift, 1'b0);
        chk({31'h0, n == 3}, 32'h1);
        waitv(base, 1'b0);
        chk({31'h0, n >= 8}, 32'h1);
        @(posedge clk);
        chk({30'h0, dynb, irq}, 32'h3);
        bus(REG_IRQ_CLR, 1'b1, 32'hf);
        rdchk(REG_IRQ_STAT, 32'h2, 32'h0);
        chk({31'h0, irq}, 32'h0);
        stop_cmd <= 1'b0;
        waitv(dynb, 1'b0);
        bus(REG_CTRL, 1'b1, 32'h22);
        stop_cmd <= 1'b1;
        waitv(dynb, 1'b1);
        chk({31'h0, dec}, 32'h0);
        stop_cmd <= 1'b0;
        bus(REG_CTRL, 1'b1, 32'h02);
        waitv(dynb, 1'b0);
        spd <= 16'sd1000;
        stop_cmd <= 1'b1;
        waitv(dec, 1'b1);
        lim <= 1'b1;
        waitv(sud, 1'b1);
        spd <= 16'sd0;
        waitv(dynb, 1'b1);
        chk({31'h0, dec}, 32'h0);
        lim <= 1'b0;
        stop_cmd <= 1'b0;
        waitv(dynb, 1'b0);
        alm <= 1'b1;
        almdb <= 1'b1;
        waitv(dynb, 1'b1);
        chk({31'h0, dec}, 32'h0);
        for (int k = 0; k < 2; k++) begin
            clr_cmd <= 1'b1;
            repeat (8) @(posedge clk);
            clr_cmd <= 1'b0;
            repeat (8) @(posedge clk);
            rdchk(REG_STATUS, 32'h80, k == 0 ? 32'h80 : 32'h0);
            alm <= 1'b0;
            almdb <= 1'b0;
        end
        waitv(dynb, 1'b0);
        spd <= 16'sd1000;
        stop_cmd <= 1'b1;
        waitv(dec, 1'b1);
        alm <= 1'b1;
        almdb <= 1'b1;
        waitv(dynb, 1'b1);
        chk({31'h0, dec}, 32'h0);
        alm <= 1'b0;
        almdb <= 1'b0;
        bus(REG_ALM_CLR, 1'b1, 32'h1);
        rdchk(REG_STATUS, 32'h80, 32'h0);
        end_of_test();
    end
endmodule // forced_stop_decel_sequencer_tb
